// ### rtl/sif_pkg.sv
/*
  constants for the slot interrupt status flags: register offsets, field
  layout and reset values.
  assumes a 16-bit register map reached by word address.
*/
`default_nettype none

package sif_pkg;

  // slot count and register geometry
  localparam int unsigned SIF_NSLOT = 12;
  localparam int unsigned SIF_ADDR_W = 16;
  localparam int unsigned SIF_DATA_W = 16;

  // register offsets
  localparam logic [15:0] SIF_ADDR_DATA_STATUS = 16'h0001;
  localparam logic [15:0] SIF_ADDR_LEV0_STATUS = 16'h0002;
  localparam logic [15:0] SIF_ADDR_LEV1_STATUS = 16'h0003;
  localparam logic [15:0] SIF_ADDR_CLEAR_ON_READ = 16'h0007;

  // field layout: slot flags in bits 11..0
  localparam int unsigned SIF_SLOT_LSB = 0;
  localparam int unsigned SIF_SLOT_MSB = 11;

  // reset values
  localparam logic [11:0] SIF_FLAGS_RESET = 12'h000;
  localparam logic [11:0] SIF_COREN_RESET = 12'hfff;
  localparam logic [15:0] SIF_RDATA_RESET = 16'h0000;

endpackage

`default_nettype wire

// ### rtl/sif_flag_bank.sv
/*
  sticky flag bank: one flag per slot, set by hardware events and cleared
  by per-bit clear strobes, set taking priority.
  assumes set and clear strobes synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sif_flag_bank #(
  parameter int unsigned WIDTH = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // events
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // flags
  output logic [WIDTH-1:0] flags
);

  // one sticky cell per slot
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_cell
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flags[g] <= 1'b0;
        end else if (set_i[g]) begin
          flags[g] <= 1'b1;
        end else if (clr_i[g]) begin
          flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### rtl/sif_status_flags.sv
/*
  slot interrupt status flags: data-update, level 0 and level 1 flags per
  slot, plus per-slot clear-on-read enables, on a simple register port.
  assumes register strobes, slot update strobes and criterion results are
  synchronous to clk; read data appear one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module sif_status_flags #(
  parameter int unsigned NSLOT = sif_pkg::SIF_NSLOT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rd_valid,
  // slot processing
  input wire logic [NSLOT-1:0] slot_update,
  input wire logic [NSLOT-1:0] slot_lev0_met,
  input wire logic [NSLOT-1:0] slot_lev1_met,
  input wire logic [NSLOT-1:0] slot_data_read,
  // flag state
  output logic [NSLOT-1:0] data_flags,
  output logic [NSLOT-1:0] lev0_flags,
  output logic [NSLOT-1:0] lev1_flags,
  output logic [NSLOT-1:0] coren_flags
);

  logic wr_data;
  logic wr_lev0;
  logic wr_lev1;
  logic wr_coren;
  logic [NSLOT-1:0] wr_bits;
  logic [NSLOT-1:0] data_clr;
  logic [NSLOT-1:0] lev0_set;
  logic [NSLOT-1:0] lev1_set;
  logic [15:0] rdata_next;

  // address decode
  assign wr_data = reg_wr && (reg_addr == sif_pkg::SIF_ADDR_DATA_STATUS);
  assign wr_lev0 = reg_wr && (reg_addr == sif_pkg::SIF_ADDR_LEV0_STATUS);
  assign wr_lev1 = reg_wr && (reg_addr == sif_pkg::SIF_ADDR_LEV1_STATUS);
  assign wr_coren = reg_wr && (reg_addr == sif_pkg::SIF_ADDR_CLEAR_ON_READ);
  assign wr_bits = reg_wdata[sif_pkg::SIF_SLOT_MSB:sif_pkg::SIF_SLOT_LSB];

  // data-update clears: write one, or slot data read with enable
  assign data_clr = ({NSLOT{wr_data}} & wr_bits)
                  | (slot_data_read & coren_flags);

  // level criteria taken only on the update strobe
  assign lev0_set = slot_update & slot_lev0_met;
  assign lev1_set = slot_update & slot_lev1_met;

  // data-update flags, all slots
  sif_flag_bank #(
    .WIDTH(NSLOT)
  ) u_data_bank (
    .clk(clk),
    .rst(rst),
    .set_i(slot_update),
    .clr_i(data_clr),
    .flags(data_flags)
  );

  // level 0 flags
  sif_flag_bank #(
    .WIDTH(NSLOT)
  ) u_lev0_bank (
    .clk(clk),
    .rst(rst),
    .set_i(lev0_set),
    .clr_i({NSLOT{wr_lev0}} & wr_bits),
    .flags(lev0_flags)
  );

  // level 1 flags
  sif_flag_bank #(
    .WIDTH(NSLOT)
  ) u_lev1_bank (
    .clk(clk),
    .rst(rst),
    .set_i(lev1_set),
    .clr_i({NSLOT{wr_lev1}} & wr_bits),
    .flags(lev1_flags)
  );

  // clear-on-read enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coren_flags <= sif_pkg::SIF_COREN_RESET;
    end else if (wr_coren) begin
      coren_flags <= wr_bits;
    end
  end

  // read mux, upper bits zero
  always_comb begin
    rdata_next = sif_pkg::SIF_RDATA_RESET;
    unique case (reg_addr)
      sif_pkg::SIF_ADDR_DATA_STATUS: rdata_next[NSLOT-1:0] = data_flags;
      sif_pkg::SIF_ADDR_LEV0_STATUS: rdata_next[NSLOT-1:0] = lev0_flags;
      sif_pkg::SIF_ADDR_LEV1_STATUS: rdata_next[NSLOT-1:0] = lev1_flags;
      sif_pkg::SIF_ADDR_CLEAR_ON_READ: rdata_next[NSLOT-1:0] = coren_flags;
      default: rdata_next = sif_pkg::SIF_RDATA_RESET;
    endcase
  end

  // registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= sif_pkg::SIF_RDATA_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_update_sets;
    (|slot_update) |=> ((data_flags & $past(slot_update)) == $past(slot_update));
  endproperty
  a_update_sets: assert property (p_update_sets) else $error("update did not set flag");

  property p_set_wins;
    (wr_data && (|(wr_bits & slot_update))) |=> ((data_flags & $past(wr_bits & slot_update)) != '0);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_w1c_data;
    (wr_data && ((slot_update & wr_bits) == '0)) |=> ((data_flags & $past(wr_bits)) == '0);
  endproperty
  a_w1c_data: assert property (p_w1c_data) else $error("write one left data flag");

  property p_w0_keeps;
    (wr_data && (slot_data_read == '0))
      |=> ((data_flags & $past(data_flags & ~wr_bits)) == $past(data_flags & ~wr_bits));
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared flag");

  property p_clear_on_read;
    (|(slot_data_read & coren_flags & ~slot_update))
      |=> ((data_flags & $past(slot_data_read & coren_flags & ~slot_update)) == '0);
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("read did not clear");

  property p_read_no_coren;
    (!wr_data && (|(slot_data_read & ~coren_flags & data_flags)))
      |=> ((data_flags & $past(slot_data_read & ~coren_flags & data_flags))
           == $past(slot_data_read & ~coren_flags & data_flags));
  endproperty
  a_read_no_coren: assert property (p_read_no_coren) else $error("read cleared flag with enable off");

  property p_persist;
    (!reg_wr && ((slot_data_read & coren_flags) == '0))
      |=> ((data_flags & $past(data_flags)) == $past(data_flags));
  endproperty
  a_persist: assert property (p_persist) else $error("flag dropped without clear");

  property p_lev0_set;
    (|lev0_set) |=> ((lev0_flags & $past(lev0_set)) == $past(lev0_set));
  endproperty
  a_lev0_set: assert property (p_lev0_set) else $error("level 0 flag not set");

  property p_lev1_set;
    (|lev1_set) |=> ((lev1_flags & $past(lev1_set)) == $past(lev1_set));
  endproperty
  a_lev1_set: assert property (p_lev1_set) else $error("level 1 flag not set");

  property p_lev_rise_cause;
    1'b1 |=> (((lev0_flags & ~$past(lev0_flags)) & ~$past(slot_update & slot_lev0_met)) == '0)
         && (((lev1_flags & ~$past(lev1_flags)) & ~$past(slot_update & slot_lev1_met)) == '0);
  endproperty
  a_lev_rise_cause: assert property (p_lev_rise_cause) else $error("level flag set without update");

  property p_lev_clear_only_w1;
    !(wr_lev0 || wr_lev1)
      |=> ((lev0_flags & $past(lev0_flags)) == $past(lev0_flags))
       && ((lev1_flags & $past(lev1_flags)) == $past(lev1_flags));
  endproperty
  a_lev_clear_only_w1: assert property (p_lev_clear_only_w1) else $error("level flag lost");

  property p_reserved_zero;
    (reg_rd && (reg_addr == sif_pkg::SIF_ADDR_LEV0_STATUS || reg_addr == sif_pkg::SIF_ADDR_LEV1_STATUS))
      |=> (reg_rd_valid && (reg_rdata[15:12] == 4'h0));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_after_reset;
    @(posedge clk) $past(rst) |-> (data_flags == '0) && (lev0_flags == '0) && (lev1_flags == '0)
      && (coren_flags == sif_pkg::SIF_COREN_RESET);
  endproperty
  a_after_reset: assert property (disable iff (1'b0) p_after_reset) else $error("bad reset state");

  c_set_and_clear: cover property (wr_data && (|(wr_bits & slot_update)));
  c_clear_on_read: cover property (|(slot_data_read & coren_flags & data_flags));
  c_lev_both: cover property (|(lev0_set & lev1_set));
  c_coren_off: cover property (|(slot_data_read & ~coren_flags & data_flags));

endmodule

`default_nettype wire

// ### test/sif_testbench.sv
/*
  self-checking bench for the slot interrupt status flags.
  assumes sif_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk;
  logic rst;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic reg_rd_valid;
  logic [11:0] slot_update;
  logic [11:0] slot_lev0_met;
  logic [11:0] slot_lev1_met;
  logic [11:0] slot_data_read;
  logic [11:0] data_flags;
  logic [11:0] lev0_flags;
  logic [11:0] lev1_flags;
  logic [11:0] coren_flags;
  int num_errors;
  int compares;

  sif_status_flags dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .slot_update(slot_update), .slot_lev0_met(slot_lev0_met), .slot_lev1_met(slot_lev1_met),
    .slot_data_read(slot_data_read), .data_flags(data_flags), .lev0_flags(lev0_flags),
    .lev1_flags(lev1_flags), .coren_flags(coren_flags));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one cycle of stimulus, then strobes low; outputs settled on return
  task automatic step(input logic [15:0] a, input logic [15:0] d, input logic w, input logic r,
    input logic [11:0] u, input logic [11:0] m0, input logic [11:0] m1, input logic [11:0] dr);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= r;
    slot_update <= u;
    slot_lev0_met <= m0;
    slot_lev1_met <= m1;
    slot_data_read <= dr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    slot_update <= 12'h000;
    slot_data_read <= 12'h000;
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    step(a, d, 1'b1, 1'b0, 12'h000, 12'h000, 12'h000, 12'h000);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    step(a, 16'h0000, 1'b0, 1'b1, 12'h000, 12'h000, 12'h000, 12'h000);
    chk({15'h0000, reg_rd_valid}, 16'h0001);
    chk(reg_rdata, exp);
  endtask

  task automatic t_reset;
    chk({4'h0, data_flags | lev0_flags | lev1_flags}, 16'h0000);
    chk({4'h0, coren_flags}, 16'h0fff);
    rd(16'h0007, 16'h0fff);
    rd(16'h0002, 16'h0000);
  endtask

  task automatic t_set;
    step(16'h0000, 16'h0000, 1'b0, 1'b0, 12'hfff, 12'h0a5, 12'h5a0, 12'h000);
    chk({4'h0, data_flags}, 16'h0fff);
    chk({4'h0, lev0_flags}, 16'h00a5);
    chk({4'h0, lev1_flags}, 16'h05a0);
    step(16'h0000, 16'h0000, 1'b0, 1'b0, 12'h000, 12'hfff, 12'hfff, 12'h000);
    chk({4'h0, lev0_flags | lev1_flags}, 16'h05a5);
    rd(16'h0002, 16'h00a5);
    rd(16'h0003, 16'h05a0);
    rd(16'h0001, 16'h0fff);
  endtask

  task automatic t_clear;
    wr(16'h0002, 16'hf000);
    rd(16'h0002, 16'h00a5);
    wr(16'h0002, 16'h0005);
    chk({4'h0, lev0_flags}, 16'h00a0);
    wr(16'h0003, 16'hffff);
    rd(16'h0003, 16'h0000);
    wr(16'h0001, 16'h0003);
    chk({4'h0, data_flags}, 16'h0ffc);
    wr(16'h0001, 16'h0000);
    chk({4'h0, data_flags}, 16'h0ffc);
    rd(16'h0009, 16'h0000);
  endtask

  task automatic t_cor;
    step(16'h0000, 16'h0000, 1'b0, 1'b0, 12'h000, 12'h000, 12'h000, 12'h004);
    chk({4'h0, data_flags}, 16'h0ff8);
    wr(16'h0007, 16'h0000);
    step(16'h0000, 16'h0000, 1'b0, 1'b0, 12'h000, 12'h000, 12'h000, 12'h008);
    chk({4'h0, data_flags}, 16'h0ff8);
    rd(16'h0007, 16'h0000);
    // read and write-one in one cycle: read sees the value before the write
    step(16'h0001, 16'h0008, 1'b1, 1'b1, 12'h000, 12'h000, 12'h000, 12'h000);
    chk(reg_rdata, 16'h0ff8);
    chk({4'h0, data_flags}, 16'h0ff0);
  endtask

  task automatic t_prio;
    step(16'h0001, 16'h0030, 1'b1, 1'b0, 12'h010, 12'h000, 12'h000, 12'h000);
    chk({4'h0, data_flags}, 16'h0fd0);
    step(16'h0002, 16'h00a0, 1'b1, 1'b0, 12'h080, 12'h080, 12'h000, 12'h000);
    chk({4'h0, lev0_flags}, 16'h0080);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({4'h0, data_flags | lev0_flags}, 16'h0000);
    chk({4'h0, coren_flags}, 16'h0fff);
  endtask

  task automatic finish_test;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    finish_test;
  end

  initial begin
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slot_update = 12'h000;
    slot_lev0_met = 12'h000;
    slot_lev1_met = 12'h000;
    slot_data_read = 12'h000;
    num_errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset;
    t_set;
    t_clear;
    t_cor;
    t_prio;
    finish_test;
  end
endmodule

`default_nettype wire
